// ===== rtl/led_seq_cfg.svh
//  Purpose: offsets, reset values and timing counts of the LED sequencer
//  Assumes: included once per compile unit through the guard
//  Notes:   the step time is one thirty-second of a period count
`ifndef LED_SEQ_CFG_SVH
`define LED_SEQ_CFG_SVH

// ****************************************************************
//  register offsets and reset values
// ****************************************************************
`define OFS_BEH_LOW      8'h81
`define OFS_BEH_HIGH     8'h82
`define OFS_P1_PERIOD    8'h84
`define OFS_P2_PERIOD    8'h85
`define OFS_BR_PERIOD    8'h86
`define RST_BEH          8'h00
`define RST_P1_PERIOD    8'h20
`define RST_P2_PERIOD    8'h14
`define RST_BR_PERIOD    8'h5D
`define EDGE_SEL_BIT     7
`define PERIOD_MIN_CNT   7'h01

// ****************************************************************
//  timing: one period count is 32 ms, split in 32 ramp steps
// ****************************************************************
`define SYS_CLK_HZ       10000000
`define COUNT_TIME_MS    32
`define RAMP_STEPS       32
`define STEP_TIME_US     ((`COUNT_TIME_MS * 1000) / `RAMP_STEPS)
`define STEP_CYCLES      (`STEP_TIME_US * (`SYS_CLK_HZ / 1000000))
`endif

// ===== rtl/led_seq_pkg.sv
//  Purpose: types shared by the LED sequencer
//  Assumes: nothing
//  Notes:   behaviour codes follow the selector field encoding
package led_seq_pkg;
  // selector field: 00 direct, 01 pulse one, 10 pulse two, 11 breathe
  typedef enum logic [1:0] {BEH_DIRECT, BEH_PULSE1, BEH_PULSE2, BEH_BREATHE} beh_t;
  typedef enum logic [2:0] {S_IDLE, S_DIRECT, S_PULSE, S_TAIL, S_BREATHE} led_state_t;
endpackage

// ===== rtl/led_seq.sv
//  Purpose: eight-channel LED behaviour sequencer with PWM pin drives
//  Assumes: touch and output-control inputs come from logic on sys_clk_i
//  Notes:   duty limits, pulse counts, link and polarity are plain inputs
`timescale 1ns/1ps
`include "led_seq_cfg.svh"

// How it works
// - two-bit behaviour selector per channel, two registers
// - direct: active on start, inactive on stop
// - pulse one: fixed pulse count, no stop
// - pulse two: pulse while held, then tail
// - breathe: ramp min-max-min until stop
// - pulse one period seven bits, 32 ms each
// - period zero behaves as period one
// - pulse one period resets to 20h
// - bit seven picks pulse one start edge
// - pulse two period register, reset 14h
// - short periods run at shortest attainable
// - PWM rate highest the duty settings allow
// - unlinked LED triggers on output-control bit
// - linked LED triggers on touch input
// - breathe period register, reset 5Dh
module led_seq #(
  parameter int STEP_CYC = `STEP_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  // triggers
  input  wire logic [7:0]  touch_i,
  input  wire logic [7:0]  link_en_i,
  input  wire logic [7:0]  led_output_control_bit_i,
  // shared shaping settings and per-channel polarity
  input  wire logic [3:0]  duty_min_i,
  input  wire logic [3:0]  duty_max_i,
  input  wire logic [2:0]  pulse_one_cnt_i,
  input  wire logic [2:0]  pulse_two_cnt_i,
  input  wire logic [7:0]  led_output_polarity_i,
  // LED pins
  output logic      [7:0]  led_pin_o
);
  import led_seq_pkg::*;

  // ****************************************************************
  //  registers
  // ****************************************************************
  logic [7:0]  beh_low_ff;
  logic [7:0]  beh_high_ff;
  logic [7:0]  p1_ff;
  logic [6:0]  p2_ff;
  logic [6:0]  br_ff;
  logic [7:0]  nxt_rdata;

  // software writes; bit seven of pulse two and breathe is not stored
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      beh_low_ff  <= `RST_BEH;
      beh_high_ff <= `RST_BEH;
      p1_ff       <= `RST_P1_PERIOD;
      p2_ff       <= 7'(`RST_P2_PERIOD);
      br_ff       <= 7'(`RST_BR_PERIOD);
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `OFS_BEH_LOW:   beh_low_ff  <= reg_wdata_i;
        `OFS_BEH_HIGH:  beh_high_ff <= reg_wdata_i;
        `OFS_P1_PERIOD: p1_ff       <= reg_wdata_i;
        `OFS_P2_PERIOD: p2_ff       <= reg_wdata_i[6:0];
        `OFS_BR_PERIOD: br_ff       <= reg_wdata_i[6:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    unique case (reg_addr_i)
      `OFS_BEH_LOW:   nxt_rdata = beh_low_ff;
      `OFS_BEH_HIGH:  nxt_rdata = beh_high_ff;
      `OFS_P1_PERIOD: nxt_rdata = p1_ff;
      `OFS_P2_PERIOD: nxt_rdata = {1'b0, p2_ff};
      `OFS_BR_PERIOD: nxt_rdata = {1'b0, br_ff};
      default:        nxt_rdata = 8'h00;
    endcase
  end

  // read data is held until the next read strobe
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  // ****************************************************************
  //  shared timing: step tick and PWM slot counter
  // ****************************************************************
  logic [31:0] step_div_ff;
  logic        tick_ff;
  logic [3:0]  pwm_ff;

  // one ramp step per tick; a count of 32 ms is 32 steps
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_div_ff <= 32'h0000_0000;
      tick_ff     <= 1'b0;
    end else if (step_div_ff == 32'(STEP_CYC - 1)) begin
      step_div_ff <= 32'h0000_0000;
      tick_ff     <= 1'b1;
    end else begin
      step_div_ff <= step_div_ff + 32'h0000_0001;
      tick_ff     <= 1'b0;
    end
  end

  // sixteen slots at the system clock: the fastest rate the duty steps allow
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_ff <= 4'h0;
    end else begin
      pwm_ff <= pwm_ff + 4'h1;
    end
  end

  // zero acts as one; every period is attainable at this step size
  function automatic logic [6:0] per_eff(input logic [6:0] raw);
    per_eff = (raw == 7'h00) ? `PERIOD_MIN_CNT : raw;
  endfunction

  // ****************************************************************
  //  per-channel sequencers
  // ****************************************************************
  led_state_t  st_ff    [8];
  logic [4:0]  phase_ff [8];
  logic [6:0]  step_ff  [8];
  logic [3:0]  rem_ff   [8];
  logic [7:0]  act_q_ff;
  logic [7:0]  act;
  logic [15:0] sel_all;

  assign sel_all = {beh_high_ff, beh_low_ff};
  // linked channels follow the touch input, others the control bit
  assign act = (link_en_i & touch_i) | (~link_en_i & led_output_control_bit_i);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_q_ff <= 8'h00;
    end else begin
      act_q_ff <= act;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 8; ch++) begin : g_ch
      beh_t       sel;
      logic       rise;
      logic       fall;
      logic [6:0] per;
      logic       step_done;
      logic       wrap;
      logic [4:0] lvl;
      logic [4:0] dmin;
      logic [4:0] dmax;
      logic [9:0] span;
      logic [4:0] duty;

      assign sel  = beh_t'(sel_all[2*ch +: 2]);
      assign rise = act[ch] & ~act_q_ff[ch];
      assign fall = ~act[ch] & act_q_ff[ch];
      assign per  = (sel == BEH_PULSE1) ? per_eff(p1_ff[6:0]) :
                    (sel == BEH_PULSE2) ? per_eff(p2_ff) : per_eff(br_ff);
      assign step_done = tick_ff && (step_ff[ch] >= per - 7'h01);
      assign wrap      = step_done && (phase_ff[ch] == 5'h1F);

      // ramp shape: up over sixteen steps, down over sixteen (each half)
      assign lvl  = (phase_ff[ch] <= 5'h10) ? phase_ff[ch] : 5'(6'h20 - {1'b0, phase_ff[ch]});
      assign dmin = {1'b0, duty_min_i};
      assign dmax = {1'b0, duty_max_i} + 5'h01;
      // widen before the product: a five-bit product would wrap at full swing
      assign span = (dmax > dmin) ? 10'(dmax - dmin) * 10'(lvl) : 10'h000;
      assign duty = (st_ff[ch] == S_IDLE)   ? dmin :
                    (st_ff[ch] == S_DIRECT) ? dmax : 5'(dmin + span[8:4]);

      // behaviour machine; triggers are ignored in states that do not stop
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          st_ff[ch]  <= S_IDLE;
          rem_ff[ch] <= 4'h0;
        end else begin
          unique case (st_ff[ch])
            S_IDLE: begin
              unique case (sel)
                BEH_DIRECT:  if (rise) st_ff[ch] <= S_DIRECT;
                BEH_PULSE1: begin
                  if (p1_ff[`EDGE_SEL_BIT] ? fall : rise) begin
                    st_ff[ch]  <= S_PULSE;
                    rem_ff[ch] <= {1'b0, pulse_one_cnt_i} + 4'h1;
                  end
                end
                BEH_PULSE2:  if (rise) st_ff[ch] <= S_PULSE;
                BEH_BREATHE: if (rise) st_ff[ch] <= S_BREATHE;
              endcase
            end
            S_DIRECT: if (fall) st_ff[ch] <= S_IDLE;
            S_PULSE: begin
              if (sel == BEH_PULSE2) begin
                if (fall) begin
                  st_ff[ch]  <= S_TAIL;
                  rem_ff[ch] <= {1'b0, pulse_two_cnt_i} + 4'h1;
                end
              end else if (wrap) begin
                if (rem_ff[ch] <= 4'h1) st_ff[ch] <= S_IDLE;
                rem_ff[ch] <= rem_ff[ch] - 4'h1;
              end
            end
            S_TAIL: begin
              if (wrap) begin
                if (rem_ff[ch] <= 4'h1) st_ff[ch] <= S_IDLE;
                rem_ff[ch] <= rem_ff[ch] - 4'h1;
              end
            end
            S_BREATHE: if (fall) st_ff[ch] <= S_IDLE;
            default: st_ff[ch] <= S_IDLE;
          endcase
        end
      end

      // ramp stepper restarts at minimum on every start
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          phase_ff[ch] <= 5'h00;
          step_ff[ch]  <= 7'h00;
        end else if (st_ff[ch] == S_IDLE || st_ff[ch] == S_DIRECT) begin
          phase_ff[ch] <= 5'h00;
          step_ff[ch]  <= 7'h00;
        end else if (step_done) begin
          phase_ff[ch] <= phase_ff[ch] + 5'h01;
          step_ff[ch]  <= 7'h00;
        end else if (tick_ff) begin
          step_ff[ch]  <= step_ff[ch] + 7'h01;
        end
      end

      // pin drive; polarity zero means the pin sinks when lit
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          led_pin_o[ch] <= 1'b1;
        end else begin
          led_pin_o[ch] <= ({1'b0, pwm_ff} < duty) ^ ~led_output_polarity_i[ch];
        end
      end
    end
  endgenerate

  // ****************************************************************
  //  assertions on the first four channels and the register port
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_sel_write: assert property (reg_wr_i && reg_addr_i == `OFS_BEH_LOW |=>
    beh_low_ff == $past(reg_wdata_i)) else $error("behaviour write lost");
  a_direct_start: assert property (st_ff[0] == S_IDLE && sel_all[1:0] == 2'b00
    && act[0] && !act_q_ff[0] |=> st_ff[0] == S_DIRECT) else $error("direct not started");
  a_pulse_hold: assert property (st_ff[1] == S_PULSE && sel_all[3:2] == 2'b01
    && !g_ch[1].wrap |=> st_ff[1] == S_PULSE) else $error("pulse one stopped early");
  a_tail_entry: assert property (st_ff[2] == S_PULSE && sel_all[5:4] == 2'b10
    && g_ch[2].fall |=> st_ff[2] == S_TAIL ##1 st_ff[2] != S_PULSE)
    else $error("pulse two tail missed");
  a_breathe_stop: assert property (st_ff[3] == S_BREATHE && g_ch[3].fall
    |=> st_ff[3] == S_IDLE) else $error("breathe did not stop");
  a_period_zero: assert property (sel_all[3:2] == 2'b01 && p1_ff[6:0] == 7'h00
    |-> g_ch[1].per == 7'h01) else $error("period zero not taken as one");
  a_edge_select: assert property (st_ff[1] == S_IDLE && sel_all[3:2] == 2'b01
    && p1_ff[7] && g_ch[1].fall |=> st_ff[1] == S_PULSE) else $error("release start missed");
  a_p2_top_zero: assert property (reg_rd_i && reg_addr_i == `OFS_P2_PERIOD
    |=> reg_rdata_o[7] == 1'b0) else $error("pulse two bit seven not zero");

  c_direct:  cover property (st_ff[0] == S_DIRECT ##1 st_ff[0] == S_IDLE);
  c_pulse1:  cover property (st_ff[1] == S_PULSE && sel_all[3:2] == 2'b01 ##1 st_ff[1] == S_IDLE);
  c_tail:    cover property (st_ff[2] == S_TAIL ##1 st_ff[2] == S_IDLE);
  c_breathe: cover property (st_ff[3] == S_BREATHE && g_ch[3].wrap);
endmodule

// ===== tb/led_load_model.sv
// Purpose: LED loads hanging on the sequencer pins
// Assumes: push-pull pins, no pull resistor on the line
// Notes:   lit follows the polarity chosen for each channel
`timescale 1ns/1ps
module led_load_model (
  // pins and polarity
  input  wire logic [7:0] led_pin_i,
  input  wire logic [7:0] led_output_polarity_i,
  // lit state of each LED
  output logic      [7:0] lit_o
);
  // ****************************************************************
  //  load
  // ****************************************************************
  // an LED conducts only while its pin sits at the lit level
  assign lit_o = ~(led_pin_i ^ led_output_polarity_i);
endmodule

// ===== tb/led_behavior_pulse_sequencer_tb.sv
// Purpose: self-checking bench of the LED behaviour sequencer
// Assumes: STEP_CYC of 4, so one period count is 128 cycles
// Notes:   brightness is judged by counting lit cycles on the loads
`timescale 1ns/1ps
module led_behavior_pulse_sequencer_tb;
  // ****************************************************************
  //  stimulus and observed signals
  // ****************************************************************
  logic       sys_clk_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic       wr_s      = 1'b0;
  logic       rd_s      = 1'b0;
  logic [7:0] addr      = 8'h00;
  logic [7:0] wdata     = 8'h00;
  logic [7:0] touch     = 8'h00;
  logic [7:0] link      = 8'h00;
  logic [7:0] ctl       = 8'h00;
  logic [7:0] pol       = 8'h55;
  logic [2:0] c1        = 3'h0;
  logic [2:0] c2        = 3'h0;
  logic [3:0] dmin_s    = 4'h0;
  logic [3:0] dmax_s    = 4'hF;
  logic [7:0] rdata;
  logic [7:0] pins;
  logic [7:0] lit;
  int         fails     = 0;
  int         n_tests   = 0;
  int         cnt;
  int         last;
  // 100 ns period
  always #50 sys_clk_i = ~sys_clk_i;
  led_seq #(.STEP_CYC(4)) DUT (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .touch_i(touch),
    .link_en_i(link), .led_output_control_bit_i(ctl), .duty_min_i(dmin_s),
    .duty_max_i(dmax_s), .pulse_one_cnt_i(c1), .pulse_two_cnt_i(c2),
    .led_output_polarity_i(pol), .led_pin_o(pins));
  led_load_model loads (.led_pin_i(pins), .led_output_polarity_i(pol), .lit_o(lit));
  // ****************************************************************
  //  tasks: every task starts and ends just after a falling edge
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge sys_clk_i);
    wr_s = 1'b0;
    // let an edge pass so a following write does not re-raise the strobe at once
    @(negedge sys_clk_i);
  endtask
  // read data is registered, so it is looked at one cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    addr = a;
    rd_s = 1'b1;
    @(negedge sys_clk_i);
    rd_s = 1'b0;
    @(negedge sys_clk_i);
    chk(what, 16'(rdata), 16'(exp));
  endtask
  // counts lit cycles of one channel and the index of the last lit one
  task automatic watch(input int ch, input int n);
    cnt = 0;
    last = -1;
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk_i);
      if (lit[ch] === 1'b1) begin
        cnt++;
        last = i;
      end
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************************************
  //  watchdog: the sequence needs about 4000 cycles
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    test_done();
  end
  // ****************************************************************
  //  main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    rd(8'h81, 8'h00, "beh_low");
    rd(8'h82, 8'h00, "beh_high");
    rd(8'h84, 8'h20, "p1_period");
    rd(8'h85, 8'h14, "p2_period");
    rd(8'h86, 8'h5D, "br_period");
    rd(8'h83, 8'h00, "unmapped");
    wr(8'h85, 8'hFF);
    rd(8'h85, 8'h7F, "p2_top_bit");
    wr(8'h81, 8'hE4);
    rd(8'h81, 8'hE4, "beh_low_rw");
    wr(8'h82, 8'h40);
    wr(8'h85, 8'h01);
    wr(8'h86, 8'h01);
    // direct on channel 0, full duty when lit, none when off
    ctl[0] = 1'b1;
    watch(0, 2);
    watch(0, 32);
    chk("direct_on", 16'(cnt), 16'd32);
    ctl[0] = 1'b0;
    watch(0, 2);
    watch(0, 32);
    chk("direct_off", 16'(cnt), 16'd0);
    link[0] = 1'b1;
    ctl[0] = 1'b1;
    watch(0, 34);
    chk("linked_ctl", 16'(cnt), 16'd0);
    touch[0] = 1'b1;
    watch(0, 2);
    watch(0, 32);
    chk("linked_touch", 16'(cnt), 16'd32);
    touch[0] = 1'b0;
    ctl[0] = 1'b0;
    link[0] = 1'b0;
    watch(0, 4);
    // pulse one on channel 1: a clear mid-run must not stop it
    for (int p = 0; p < 3; p++) begin
      wr(8'h84, 8'(p));
      ctl[1] = 1'b1;
      watch(1, 2);
      ctl[1] = 1'b0;
      watch(1, 400);
      chk("p1_lit", 16'(cnt > 0), 16'd1);
      chk("p1_end", 16'(last > 64 * (p ? p : 1) && last < 128 * (p ? p : 1) + 4), 16'd1);
    end
    c1 = 3'h1;
    wr(8'h84, 8'h01);
    ctl[1] = 1'b1;
    watch(1, 400);
    chk("p1_two_pulses", 16'(last > 192 && last < 260), 16'd1);
    ctl[7] = 1'b1;
    watch(7, 300);
    chk("ch8_pulse", 16'(cnt > 0), 16'd1);
    c1 = 3'h0;
    ctl[1] = 1'b0;
    wr(8'h84, 8'h81);
    ctl[1] = 1'b1;
    watch(1, 200);
    chk("p1_rise_ignored", 16'(cnt), 16'd0);
    ctl[1] = 1'b0;
    watch(1, 200);
    chk("p1_fall_starts", 16'(cnt > 0), 16'd1);
    // pulse two on channel 2: repeats while held, settles after the tail
    ctl[2] = 1'b1;
    watch(2, 256);
    watch(2, 256);
    chk("p2_repeat", 16'(cnt > 0), 16'd1);
    ctl[2] = 1'b0;
    watch(2, 140);
    watch(2, 128);
    chk("p2_settle", 16'(cnt), 16'd0);
    // breathe on channel 3 beside a direct channel 0
    ctl[3] = 1'b1;
    ctl[0] = 1'b1;
    watch(3, 256);
    watch(3, 256);
    chk("breathe_runs", 16'(cnt > 0), 16'd1);
    watch(0, 32);
    chk("direct_beside", 16'(cnt), 16'd32);
    ctl[3] = 1'b0;
    watch(3, 4);
    watch(3, 128);
    chk("breathe_stop", 16'(cnt), 16'd0);
    // shared duty limits: idle channel 4 at minimum, direct channel 0 at maximum
    dmin_s = 4'h3;
    dmax_s = 4'h7;
    watch(4, 2);
    watch(4, 32);
    chk("idle_min_duty", 16'(cnt), 16'd6);
    watch(0, 32);
    chk("direct_max_duty", 16'(cnt), 16'd16);
    test_done();
  end
endmodule
